/* logic/periodic_timer_guard.sv */
// Periodic timer and service guard on the slow clock
// Function
// R1: All counting follows the slow clock, which never exceeds 100 kHz.
// R2: Prescaler divides slow clock by 1, 2, 4, 8, 16 or 32.
// R3: Timer is a 16-bit down counter stepping on each prescaled edge.
// R4: At zero the timer reloads itself and keeps counting.
// R5: Software programs reload values from 0001 to ffff only.
// R6: At zero the tick is high one prescaled cycle and sets terminal flag.
// R7: Each tick raises the interrupt when the tick enable is set.
// R8: New reload value only takes effect at the next reload.
// R9: Restart bit reloads timer on next prescaled edge, then self-clears.
// R10: Software waits for restart to clear before entering low power.
// R11: Guard is an 8-bit down counter on its selected clock.
// R12: Guard idle after reset; first count or key write starts it.
// R13: Guard clock is the tick or the prescaled clock.
// R14: Without key mode, a count write reloads the guard with that value.
// R15: In key mode, writing the key reloads the stored count.
// R16: Late service and too frequent service both raise a guard error.
// R17: In key mode a wrong key raises a guard error.
// R18: A guard error asserts a full device reset.
// R19: Locked registers ignore writes, read garbage, until device reset. Here locked registers read as zero.
// R20: Clocks and counters keep running in power save and idle.
// R21: Only the key register is reachable outside active mode.
// R22: In halt all state freezes and later resumes unchanged.
// R23: Software waits five slow cycles after restart before power save.
// R24: Configuration bits are set-only and clear on reset.
// R25: Clock select zero picks the tick, one the prescaled clock.
// R26: Two services within one guard clock cycle are too often.
// R27: Reload register resets to ffff.
// R28: Late means guard underflows past zero before a valid service.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_guard (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Slow clock pin
  input wire logic slow_clock_i,
  // Power mode
  input wire logic active_mode_i,
  input wire logic halt_mode_i,
  // Register port
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Timer outputs
  output logic prescaled_clk_o,
  output logic tick_out_o,
  output logic real_time_interrupt_o,
  // Guard outputs
  output logic guard_running_o,
  output logic device_reset_o
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    logic slow_s1;
    logic slow_s2;
    logic slow_s3;
    logic [guard_pkg::CFG_W-1:0] module_configuration;
    logic [2:0] prescaler_setting;
    logic [15:0] timer_reload_value;
    logic [15:0] tcnt;
    logic tick_out;
    logic irq;
    logic restart;
    logic tick_interrupt_enable;
    logic terminal_count_flag;
    logic [7:0] guard_count_register;
    logic [15:0] rdata;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;

  logic slow_edge;
  logic pre_edge;
  logic guard_edge;
  logic tick_rise;
  logic acc_ok;
  logic wr_cfg;
  logic wr_presc;
  logic wr_timer;
  logic wr_gcnt;
  logic wr_key;
  logic key_mode;
  logic guard_load;
  logic [7:0] guard_load_val;
  logic bad_key;
  logic guard_run;
  logic [7:0] guard_cnt;
  logic guard_err;

  // --------------------------------------------------------------
  // Prescaler and guard counter
  // --------------------------------------------------------------
  slow_prescaler u_prescaler (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .slow_edge_i(slow_edge),
    .div_sel_i(s.prescaler_setting),
    .pre_edge_o(pre_edge)
  );

  service_guard u_guard (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .guard_edge_i(guard_edge),
    .load_i(guard_load),
    .load_val_i(guard_load_val),
    .bad_key_i(bad_key),
    .running_o(guard_run),
    .count_o(guard_cnt),
    .error_o(guard_err)
  );

  // --------------------------------------------------------------
  // Event and access decode
  // --------------------------------------------------------------
  always_comb begin
    // Halt gates every event, so all counts hold their place
    slow_edge = s.slow_s2 && !s.slow_s3 && !halt_mode_i; // R1 R20 R22
    // Low power modes, halt included, lose the register port
    acc_ok = active_mode_i && !halt_mode_i; // R21
    wr_cfg = wr_i && acc_ok && (addr_i == guard_pkg::CFG_OFS) &&
             !s.module_configuration[guard_pkg::LOCK_CFG_BIT]; // R19
    wr_presc = wr_i && acc_ok && (addr_i == guard_pkg::PRESC_OFS) &&
               !s.module_configuration[guard_pkg::LOCK_PRESC_BIT]; // R19
    wr_timer = wr_i && acc_ok &&
               !s.module_configuration[guard_pkg::LOCK_TIMER_BIT]; // R19
    wr_gcnt = wr_i && acc_ok && (addr_i == guard_pkg::GCNT_OFS) &&
              !s.module_configuration[guard_pkg::LOCK_GCNT_BIT]; // R19
    // Key register stays reachable in power save and idle
    wr_key = wr_i && !halt_mode_i && (addr_i == guard_pkg::GKEY_OFS); // R21
    key_mode = s.module_configuration[guard_pkg::KEY_MODE_BIT];
    tick_rise = next_s.tick_out && !s.tick_out;
    guard_edge = s.module_configuration[guard_pkg::GUARD_CLK_SEL_BIT] ?
                 pre_edge : tick_rise; // R13 R25
    guard_load = 1'b0;
    guard_load_val = wdata_i[7:0];
    bad_key = 1'b0;
    if (wr_gcnt && (!key_mode || !guard_run)) begin
      guard_load = 1'b1; // R12 R14
    end
    if (wr_key && key_mode) begin
      if (wdata_i[7:0] == guard_pkg::SERVICE_KEY) begin
        guard_load = 1'b1; // R15
        guard_load_val = s.guard_count_register; // R15
      end else begin
        bad_key = 1'b1; // R17
      end
    end
  end

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.slow_s1 = slow_clock_i;
    next_s.slow_s2 = s.slow_s1;
    next_s.slow_s3 = s.slow_s2;
    next_s.irq = 1'b0;
    // Set-only: a runaway program cannot undo protection
    if (wr_cfg) begin
      next_s.module_configuration = s.module_configuration |
                                    wdata_i[guard_pkg::CFG_W-1:0]; // R24
    end
    if (wr_presc) begin
      next_s.prescaler_setting = wdata_i[2:0]; // R2
    end
    // Counter untouched here; reload value waits for zero or a restart
    if (wr_timer && (addr_i == guard_pkg::RELOAD_OFS)) begin
      next_s.timer_reload_value = wdata_i; // R8
    end
    if (wr_timer && (addr_i == guard_pkg::TCSR_OFS)) begin
      next_s.tick_interrupt_enable = wdata_i[guard_pkg::TCSR_INTE_BIT];
      if (wdata_i[guard_pkg::TCSR_RESTART_BIT]) begin
        next_s.restart = 1'b1; // R9
      end
      if (wdata_i[guard_pkg::TCSR_TC_BIT]) begin
        next_s.terminal_count_flag = 1'b0;
      end
    end
    if (wr_gcnt) begin
      next_s.guard_count_register = wdata_i[7:0]; // R14 R15
    end
    if (pre_edge) begin
      next_s.tick_out = 1'b0;
      if (s.restart) begin
        next_s.tcnt = s.timer_reload_value; // R9
        next_s.restart = 1'b0; // R9
      end else if (s.tcnt == 16'h0000) begin
        next_s.tcnt = s.timer_reload_value; // R4
      end else begin
        next_s.tcnt = 16'(s.tcnt - 16'h0001); // R3
        // Zero is held for one full prescaled cycle
        next_s.tick_out = (s.tcnt == 16'h0001); // R6
      end
    end
    // Set wins over a clear in the same cycle
    if (next_s.tick_out && !s.tick_out) begin
      next_s.terminal_count_flag = 1'b1; // R6
      next_s.irq = s.tick_interrupt_enable; // R7
    end
    next_s.rdata = 16'h0000;
    // Locked registers read as zero
    if (rd_i && acc_ok) begin
      unique case (addr_i)
        guard_pkg::CFG_OFS: begin
          if (!s.module_configuration[guard_pkg::LOCK_CFG_BIT]) begin // R19
            next_s.rdata = 16'(s.module_configuration);
          end
        end
        guard_pkg::PRESC_OFS: begin
          if (!s.module_configuration[guard_pkg::LOCK_PRESC_BIT]) begin
            next_s.rdata = 16'(s.prescaler_setting);
          end
        end
        guard_pkg::RELOAD_OFS: begin
          if (!s.module_configuration[guard_pkg::LOCK_TIMER_BIT]) begin
            next_s.rdata = s.timer_reload_value;
          end
        end
        guard_pkg::TCSR_OFS: begin
          if (!s.module_configuration[guard_pkg::LOCK_TIMER_BIT]) begin
            next_s.rdata[guard_pkg::TCSR_RESTART_BIT] = s.restart;
            next_s.rdata[guard_pkg::TCSR_INTE_BIT] = s.tick_interrupt_enable;
            next_s.rdata[guard_pkg::TCSR_TC_BIT] = s.terminal_count_flag;
          end
        end
        guard_pkg::GCNT_OFS: begin
          if (!s.module_configuration[guard_pkg::LOCK_GCNT_BIT]) begin
            next_s.rdata = 16'(guard_cnt);
          end
        end
        default: begin
          next_s.rdata = 16'h0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.module_configuration <= guard_pkg::CFG_RST; // R24
      s.prescaler_setting <= guard_pkg::PRESC_RST;
      s.timer_reload_value <= guard_pkg::RELOAD_RST; // R27
      s.tcnt <= guard_pkg::RELOAD_RST;
      s.guard_count_register <= guard_pkg::GCNT_RST;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign rdata_o = s.rdata;
  assign prescaled_clk_o = pre_edge;
  assign tick_out_o = s.tick_out;
  assign real_time_interrupt_o = s.irq; // R7
  assign guard_running_o = guard_run;
  assign device_reset_o = guard_err; // R18

endmodule // periodic_timer_guard
`default_nettype wire

/* logic/guard_pkg.sv */
// Shared constants of the periodic timer and service guard
package guard_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] CFG_OFS = 5'h00;
  localparam logic [4:0] PRESC_OFS = 5'h04;
  localparam logic [4:0] RELOAD_OFS = 5'h08;
  localparam logic [4:0] TCSR_OFS = 5'h0c;
  localparam logic [4:0] GCNT_OFS = 5'h10;
  localparam logic [4:0] GKEY_OFS = 5'h14;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int LOCK_CFG_BIT = 0;
  localparam int LOCK_PRESC_BIT = 1;
  localparam int LOCK_TIMER_BIT = 2;
  localparam int LOCK_GCNT_BIT = 3;
  localparam int GUARD_CLK_SEL_BIT = 4;
  localparam int KEY_MODE_BIT = 5;
  localparam int CFG_W = 6;

  // ----------------------------------------------------------------
  // Timer control and status fields
  // ----------------------------------------------------------------
  localparam int TCSR_RESTART_BIT = 0;
  localparam int TCSR_INTE_BIT = 1;
  localparam int TCSR_TC_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and key
  // ----------------------------------------------------------------
  localparam logic [5:0] CFG_RST = 6'h00;
  localparam logic [2:0] PRESC_RST = 3'h0;
  localparam logic [15:0] RELOAD_RST = 16'hffff;
  localparam logic [7:0] GCNT_RST = 8'h00;
  localparam logic [7:0] SERVICE_KEY = 8'h5c;

  // Division mask of the prescaler; codes above five divide by 32
  function automatic logic [4:0] div_mask(input logic [2:0] sel);
    logic [4:0] m;
    m = 5'h1f;
    if (sel < 3'h5) begin
      m = 5'(({1'b0, 5'h01} << sel) - 6'h01);
    end
    return m;
  endfunction

endpackage

/* logic/slow_prescaler.sv */
// Prescaler that divides slow clock edges into prescaled clock edges
`timescale 1ns/1ps
`default_nettype none
module slow_prescaler (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Slow clock edge and divider code
  input wire logic slow_edge_i,
  input wire logic [2:0] div_sel_i,
  // Prescaled clock edge, one cycle
  output logic pre_edge_o
);

  typedef struct packed {
    logic [4:0] cnt;
    logic pre_edge;
  } pre_state_t;

  pre_state_t s;
  pre_state_t next_s;
  logic [4:0] mask;

  // --------------------------------------------------------------
  // Divide by 1, 2, 4, 8, 16 or 32
  // --------------------------------------------------------------
  always_comb begin
    next_s = s;
    mask = guard_pkg::div_mask(div_sel_i);
    next_s.pre_edge = 1'b0;
    if (slow_edge_i) begin // R2
      next_s.cnt = 5'(s.cnt + 5'h01);
      next_s.pre_edge = ((s.cnt & mask) == mask); // R2
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pre_edge_o = s.pre_edge;

endmodule // slow_prescaler
`default_nettype wire

/* logic/service_guard.sv */
// Eight-bit supervisory down counter with late and early checks
`timescale 1ns/1ps
`default_nettype none
module service_guard (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Guard input clock edge
  input wire logic guard_edge_i,
  // Service load and key error
  input wire logic load_i,
  input wire logic [7:0] load_val_i,
  input wire logic bad_key_i,
  // State
  output logic running_o,
  output logic [7:0] count_o,
  output logic error_o
);

  typedef struct packed {
    logic run;
    logic [7:0] cnt;
    logic serviced;
    logic err;
  } guard_state_t;

  guard_state_t s;
  guard_state_t next_s;

  // --------------------------------------------------------------
  // Counting and error detection
  // --------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (!s.err) begin
      if (guard_edge_i) begin
        next_s.serviced = 1'b0; // R26
      end
      // A key write also starts the guard, so a bad key never errs idle
      if (bad_key_i) begin
        next_s.run = 1'b1; // R12
        next_s.err = 1'b1; // R17
      end
      if (load_i) begin
        if (s.run && s.serviced) begin
          next_s.err = 1'b1; // R16 R26
        end
        next_s.run = 1'b1; // R12
        next_s.cnt = load_val_i;
        next_s.serviced = 1'b1;
      end else if (guard_edge_i && s.run) begin // R11
        if (s.cnt == 8'h00) begin
          next_s.err = 1'b1; // R16 R28
        end else begin
          next_s.cnt = 8'(s.cnt - 8'h01); // R11
        end
      end
    end
  end

  // Only a reset stops the guard once it runs
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0; // R12
    end else begin
      s <= next_s;
    end
  end

  assign running_o = s.run;
  assign count_o = s.cnt;
  assign error_o = s.err;

endmodule // service_guard
`default_nettype wire

/* verif/periodic_timer_guard_props.sv */
// Port checker of the periodic timer and service guard
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_guard_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Inputs
  input wire logic slow_clock_i,
  input wire logic active_mode_i,
  input wire logic halt_mode_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  // Outputs
  input wire logic [15:0] rdata_o,
  input wire logic prescaled_clk_o,
  input wire logic tick_out_o,
  input wire logic real_time_interrupt_o,
  input wire logic guard_running_o,
  input wire logic device_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // Three cycles so a pulse launched before halt has drained
  sequence s_frozen;
    halt_mode_i [*3];
  endsequence
  sequence s_irq_pulse;
    $rose(tick_out_o) ##1 !real_time_interrupt_o;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_irq_on_tick: assert property (real_time_interrupt_o |-> s_irq_pulse)
    else $error("interrupt without tick rise");
  a_tick_on_edge: assert property ($changed(tick_out_o) |-> $past(prescaled_clk_o))
    else $error("tick moved off a prescaled edge");
  a_pre_single: assert property (prescaled_clk_o |=> !prescaled_clk_o)
    else $error("prescaled pulse too long");
  a_halt_freeze: assert property (s_frozen |-> !prescaled_clk_o && $stable(tick_out_o) && $stable(guard_running_o))
    else $error("state moved in halt");
  a_error_sticky: assert property (device_reset_o |=> device_reset_o)
    else $error("device reset dropped");
  a_run_sticky: assert property (guard_running_o |=> guard_running_o)
    else $error("guard stopped");
  a_error_needs_run: assert property (device_reset_o |-> guard_running_o)
    else $error("error from idle guard");
  a_start_cause: assert property ($rose(guard_running_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("guard started without write");
  a_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  a_key_unread: assert property ($past(rd_i) && $past(addr_i) == guard_pkg::GKEY_OFS |-> rdata_o == 16'h0000)
    else $error("key register readable");
endmodule // periodic_timer_guard_props

bind periodic_timer_guard periodic_timer_guard_props chk_u (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_clock_i(slow_clock_i),
  .active_mode_i(active_mode_i), .halt_mode_i(halt_mode_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .prescaled_clk_o(prescaled_clk_o),
  .tick_out_o(tick_out_o), .real_time_interrupt_o(real_time_interrupt_o),
  .guard_running_o(guard_running_o), .device_reset_o(device_reset_o));
`default_nettype wire

/* verif/periodic_timer_guard_bench.sv */
// Self-checking bench of the periodic timer and service guard
`timescale 1ns/1ps
`default_nettype none
module periodic_timer_guard_bench;
  logic clk_sys_i, rst_n_i, slow_clock_i, active_mode_i, halt_mode_i;
  logic [4:0] addr_i;
  logic [15:0] wdata_i;
  logic wr_i, rd_i;
  logic [15:0] rdata_o;
  logic prescaled_clk_o, tick_out_o, real_time_interrupt_o;
  logic guard_running_o, device_reset_o;
  logic [4:0] slow_div;
  logic [15:0] rv;
  int error_cnt, samples_checked, n, m;

  periodic_timer_guard dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .slow_clock_i(slow_clock_i), .active_mode_i(active_mode_i),
    .halt_mode_i(halt_mode_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .prescaled_clk_o(prescaled_clk_o), .tick_out_o(tick_out_o),
    .real_time_interrupt_o(real_time_interrupt_o),
    .guard_running_o(guard_running_o), .device_reset_o(device_reset_o));
  // ----------------------------------------------------------------
  // Clocks and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Slow clock of 40 cycles; far above the pin limit, to keep runs short
  always @(posedge clk_sys_i) begin
    slow_div <= (slow_div == 5'h13) ? 5'h00 : slow_div + 5'h01;
    if (slow_div == 5'h13) slow_clock_i <= ~slow_clock_i;
  end
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      error_cnt++;
      $display("ERROR %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic do_reset;
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
  endtask
  // Cycles to the next prescaled pulse, bounded
  task automatic wait_pre(output int c);
    c = 0;
    do begin
      cyc(1);
      c++;
      if (c > 3000) begin
        error_cnt++;
        $display("ERROR %0t no prescaled pulse", $time);
        test_done;
      end
    end while (prescaled_clk_o !== 1'b1);
  endtask
  // Prescaled pulses from tick fall to tick rise, bounded
  task automatic tick_gap(output int p);
    int c;
    p = 0;
    c = 0;
    while (tick_out_o === 1'b1 && c < 20000) begin
      cyc(1);
      c++;
    end
    while (tick_out_o !== 1'b1 && c < 20000) begin
      cyc(1);
      c++;
      if (prescaled_clk_o === 1'b1) p++;
    end
    if (c >= 20000) begin
      error_cnt++;
      $display("ERROR %0t no tick", $time);
      test_done;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_presc;
    for (int k = 0; k < 8; k++) begin
      wr(guard_pkg::PRESC_OFS, 16'(k));
      wait_pre(m);
      wait_pre(n);
      chk_num(n, 40 << ((k > 5) ? 5 : k));
    end
    wr(guard_pkg::PRESC_OFS, 16'h0000);
  endtask
  task automatic t_timer;
    wr(guard_pkg::RELOAD_OFS, 16'h0003);
    wr(guard_pkg::TCSR_OFS, 16'h0001);
    tick_gap(n);
    chk_val({15'h0000, real_time_interrupt_o}, 16'h0000);
    tick_gap(n);
    chk_num(n, 3);
    wr(guard_pkg::TCSR_OFS, 16'h0002);
    tick_gap(n);
    chk_val({15'h0000, real_time_interrupt_o}, 16'h0001);
    rd(guard_pkg::TCSR_OFS, rv);
    chk_val(rv, 16'h0006);
    wait_pre(m);
    wr(guard_pkg::RELOAD_OFS, 16'h0005);
    tick_gap(n);
    chk_num(n, 3);
    tick_gap(n);
    chk_num(n, 5);
    halt_mode_i <= 1'b1;
    n = 0;
    for (int k = 0; k < 200; k++) begin
      cyc(1);
      if (prescaled_clk_o === 1'b1) n++;
    end
    chk_num(n, 0);
    halt_mode_i <= 1'b0;
    tick_gap(n);
    tick_gap(n);
    chk_num(n, 5);
  endtask
  task automatic t_guard;
    chk_val({15'h0000, guard_running_o}, 16'h0000);
    wr(guard_pkg::CFG_OFS, 16'h0010);
    wr(guard_pkg::GCNT_OFS, 16'h0004);
    repeat (3) begin
      wait_pre(m);
      wr(guard_pkg::GCNT_OFS, 16'h0004);
    end
    chk_val({14'h0000, guard_running_o, device_reset_o}, 16'h0002);
    wait_pre(m);
    wr(guard_pkg::GCNT_OFS, 16'h0004);
    wr(guard_pkg::GCNT_OFS, 16'h0004);
    cyc(3);
    chk_val({15'h0000, device_reset_o}, 16'h0001);
    do_reset;
    wr(guard_pkg::CFG_OFS, 16'h0010);
    // Start right after a pulse so no guard edge slips past unseen
    wait_pre(m);
    wr(guard_pkg::GCNT_OFS, 16'h0002);
    wait_pre(m);
    wait_pre(m);
    chk_val({15'h0000, device_reset_o}, 16'h0000);
    wait_pre(m);
    cyc(3);
    chk_val({15'h0000, device_reset_o}, 16'h0001);
    do_reset;
  endtask
  task automatic t_key;
    wr(guard_pkg::CFG_OFS, 16'h0030);
    wr(guard_pkg::GCNT_OFS, 16'h0008);
    // Five slow cycles before leaving active mode
    repeat (5) wait_pre(m);
    active_mode_i <= 1'b0;
    repeat (4) begin
      wait_pre(m);
      wr(guard_pkg::GKEY_OFS, 16'h005c);
    end
    wr(guard_pkg::RELOAD_OFS, 16'h0001);
    chk_val({15'h0000, device_reset_o}, 16'h0000);
    active_mode_i <= 1'b1;
    rd(guard_pkg::RELOAD_OFS, rv);
    chk_val(rv, 16'hffff);
    wait_pre(m);
    wr(guard_pkg::GKEY_OFS, 16'h005d);
    cyc(3);
    chk_val({15'h0000, device_reset_o}, 16'h0001);
    do_reset;
  endtask
  task automatic t_lock;
    wr(guard_pkg::CFG_OFS, 16'h0004);
    wr(guard_pkg::CFG_OFS, 16'h0000);
    rd(guard_pkg::CFG_OFS, rv);
    chk_val(rv, 16'h0004);
    wr(guard_pkg::RELOAD_OFS, 16'h0007);
    rd(guard_pkg::RELOAD_OFS, rv);
    chk_val(rv, 16'h0000);
    wr(guard_pkg::CFG_OFS, 16'h0001);
    rd(guard_pkg::CFG_OFS, rv);
    chk_val(rv, 16'h0000);
    rd(5'h1c, rv);
    chk_val(rv, 16'h0000);
    do_reset;
    rd(guard_pkg::CFG_OFS, rv);
    chk_val(rv, 16'h0000);
    rd(guard_pkg::RELOAD_OFS, rv);
    chk_val(rv, 16'hffff);
  endtask
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    {rst_n_i, slow_clock_i, halt_mode_i, wr_i, rd_i} = 5'h00;
    active_mode_i = 1'b1;
    slow_div = 5'h00;
    addr_i = 5'h00;
    wdata_i = 16'h0000;
    do_reset;
    t_lock;
    t_presc;
    t_timer;
    t_guard;
    t_key;
    test_done;
  end
endmodule // periodic_timer_guard_bench
`default_nettype wire
